// >>> core/cmwg_pkg.sv
// Package for the configuration memory write guard.
// Assumes one system clock (mclk) and a separate link clock at the bus framer.
package cmwg_pkg;
  // Sizes of the parameter memories
  localparam int NPAGES = 2; // Outputs behind one bus address
  localparam int NPARAM = 4; // Parameters held per output
  // Command codes, all chosen for this block
  localparam logic [7:0] CODE_OPER = 8'h41; // On/off and margin
  localparam logic [7:0] CODE_ONOFF = 8'h42; // On/off configuration
  localparam logic [7:0] CODE_VOUT = 8'h43; // output_voltage_setpoint
  localparam logic [7:0] CODE_TRIM = 8'h44; // Trim, no user store slot
  localparam logic [7:0] CODE_WP = 8'h50; // write_lock_control
  localparam logic [7:0] CODE_PAGE = 8'h51; // output_selector
  localparam logic [7:0] CODE_ST_DFLT_ALL = 8'h60;
  localparam logic [7:0] CODE_LD_DFLT_ALL = 8'h61;
  localparam logic [7:0] CODE_ST_USER_ALL = 8'h62;
  localparam logic [7:0] CODE_LD_USER_ALL = 8'h63;
  localparam logic [7:0] CODE_ST_DFLT_ONE = 8'h64; // store_one_to_factory
  localparam logic [7:0] CODE_LD_DFLT_ONE = 8'h65; // restore_one_from_factory
  localparam logic [7:0] CODE_ST_USER_ONE = 8'h66; // store_one_to_user
  localparam logic [7:0] CODE_LD_USER_ONE = 8'h67; // restore_one_from_user
  // Parameter slots in each memory
  localparam logic [1:0] IDX_OPER = 2'h0;
  localparam logic [1:0] IDX_ONOFF = 2'h1;
  localparam logic [1:0] IDX_VOUT = 2'h2;
  localparam logic [1:0] IDX_TRIM = 2'h3;
  // Reset contents of the parameters
  localparam logic [7:0] RST_OPER = 8'h80;
  localparam logic [7:0] RST_ONOFF = 8'h1E;
  localparam logic [7:0] RST_VOUT = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_WP = 8'h00;
  localparam logic [7:0] RST_PAGE = 8'h00;
  // Write lock bits
  localparam int WP_ALL = 7;
  localparam int WP_CTRL = 6;
  localparam int WP_SETPT = 5;
  localparam int WP_REST = 0;
  // Selector values
  localparam logic [7:0] PAGE_ALL = 8'hFF;
  localparam logic [7:0] PAGE_MULTI_MAX = 8'h1F;
  // On/off configuration and operation bits
  localparam int OPER_ON = 7;
  localparam int CFG_GATED = 4;
  localparam int CFG_USE_CMD = 3;
  localparam int CFG_USE_PIN = 2;
  localparam int CFG_PIN_POL = 1;
  // Status word bits
  localparam int ST_CML = 1;
  localparam int ST_OFF = 6;
  localparam int ST_FAULT = 11;
  // Notification addresses
  localparam logic [6:0] HOST_ADDR = 7'h08; // 0001 000
  localparam logic [6:0] OWN_ADDR = 7'h2A; // Arbitrary value
  // Copy operations
  typedef enum logic [1:0] {
    CMWG_ST_DFLT = 2'b00,
    CMWG_LD_DFLT = 2'b01,
    CMWG_ST_USER = 2'b10,
    CMWG_LD_USER = 2'b11
  } cmwg_copy_t;
  // Command engine states
  typedef enum logic [1:0] {
    CMWG_IDLE = 2'b00,
    CMWG_EXEC = 2'b01,
    CMWG_COPY = 2'b10
  } cmwg_state_t;
endpackage : cmwg_pkg

// >>> core/cmwg_top.sv
// Command interpreter: write lock, selector, store copies, fault latch, notify.
// Assumes a bus framer on link_clk that hands over whole commands and
// sends notification bytes, taking link_req only while link_busy is low.
//
// How it works
// [RQ1] Fault shutdown stays latched until cleared
// [RQ2] Reset clears the latched fault
// [RQ3] Commanding off then on clears fault
// [RQ4] Notify bytes equal status word, low first
// [RQ5] Notify: host addr, own addr, two bytes
// [RQ6] Reads always allowed regardless of lock
// [RQ7] Lock bit 7: only lock byte writable
// [RQ8] Lock bit 6: adds on/off and selector
// [RQ9] Lock bit 5: adds configuration and setpoint
// [RQ10] Lock bit 0 refuses rest; zero allows all
// [RQ11] Store all copies working into factory store
// [RQ12] Restore all copies factory store into working
// [RQ13] Store all copies working into user store
// [RQ14] Restore all copies user store into working
// [RQ15] Whole copies take no data, write only
// [RQ16] Store one copies named parameter only
// [RQ17] Restore one copies named parameter back
// [RQ18] Bad or unstorable code reports failure
// [RQ19] Host should avoid copies while running
// [RQ20] Separate working memory per selector value
// [RQ21] Selector is unsigned, low values address outputs
// [RQ22] Selector FFh applies to all outputs
// [RQ23] Refused write changes nothing, reports failure
// [RQ24] Selector holds until rewritten or reset
`timescale 1ns/100ps
module cmwg_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ctrl_pin,
  input wire logic [cmwg_pkg::NPAGES-1:0] fault_in,
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_write,
  input wire logic link_has_data,
  input wire logic [7:0] link_code,
  input wire logic [7:0] link_data,
  input wire logic ntf_ack,
  output logic [cmwg_pkg::NPAGES-1:0] out_en,
  output logic busy,
  output logic link_busy,
  output logic link_rsp,
  output logic link_rsp_fail,
  output logic [7:0] link_rsp_data,
  output logic ntf_valid,
  output logic ntf_last,
  output logic [7:0] ntf_byte
);
  localparam int NP = cmwg_pkg::NPAGES;
  localparam int NQ = cmwg_pkg::NPARAM;

  // Reset synchronisers, one per domain
  logic rs1, rst_n, lr1, lrst_n;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rs1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rst_n <= rs1;
    end
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      lr1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lr1 <= 1'b1;
      lrst_n <= lr1;
    end
  end

  // Link domain
  logic lk_write, lk_has_data; // Held request, stable while busy
  logic [7:0] lk_code, lk_data;
  logic req_tgl; // Toggles once per request
  logic rsp_tgl, ntf_tgl, done_tgl; // Toggles from/to the mclk side
  logic rsp_q1, rsp_q2, rsp_q3, ntf_q1, ntf_q2, ntf_q3;
  logic [1:0] ntf_cnt; // Notification byte number
  logic m_rsp_fail;
  logic [7:0] m_rsp_data;
  logic [15:0] m_ntf_word; // Status word held for the notification
  wire rsp_edge = rsp_q2 ^ rsp_q3;
  wire ntf_edge = ntf_q2 ^ ntf_q3;
  // Byte order of a notification
  wire [7:0] ntf_sel [4];
  assign ntf_sel[0] = {cmwg_pkg::HOST_ADDR, 1'b0}; // [RQ5]
  assign ntf_sel[1] = {cmwg_pkg::OWN_ADDR, 1'b0}; // [RQ5]
  assign ntf_sel[2] = m_ntf_word[7:0]; // [RQ4]
  assign ntf_sel[3] = m_ntf_word[15:8]; // [RQ4]
  wire [1:0] ntf_cnt_nx = 2'(ntf_cnt + 2'd1);

  // Toggle synchronisers toward the link
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {rsp_q1, rsp_q2, rsp_q3} <= 3'h0;
      {ntf_q1, ntf_q2, ntf_q3} <= 3'h0;
    end else begin
      {rsp_q1, rsp_q2, rsp_q3} <= {rsp_tgl, rsp_q1, rsp_q2};
      {ntf_q1, ntf_q2, ntf_q3} <= {ntf_tgl, ntf_q1, ntf_q2};
    end
  end

  // Request capture; a request while busy is ignored
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {lk_write, lk_has_data, lk_code, lk_data} <= 18'h0_0000;
      {req_tgl, link_busy, link_rsp, link_rsp_fail} <= 4'h0;
      link_rsp_data <= 8'h00;
    end else begin
      link_rsp <= rsp_edge;
      if (link_req && !link_busy) begin
        {lk_write, lk_has_data, lk_code, lk_data} <=
          {link_write, link_has_data, link_code, link_data};
        req_tgl <= ~req_tgl;
        link_busy <= 1'b1;
      end else if (rsp_edge) begin
        link_busy <= 1'b0;
        link_rsp_fail <= m_rsp_fail;
        link_rsp_data <= m_rsp_data;
      end
    end
  end

  // Notification sender, one byte per host acknowledge
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {ntf_valid, ntf_last, done_tgl} <= 3'h0;
      ntf_cnt <= 2'h0;
      ntf_byte <= 8'h00;
    end else if (ntf_edge && !ntf_valid) begin
      ntf_valid <= 1'b1; // [RQ5]
      ntf_cnt <= 2'h0;
      ntf_byte <= ntf_sel[0];
      ntf_last <= 1'b0;
    end else if (ntf_valid && ntf_ack) begin
      if (ntf_last) begin
        ntf_valid <= 1'b0; // Stop follows the high byte
        ntf_last <= 1'b0;
        done_tgl <= ~done_tgl;
      end else begin
        ntf_cnt <= ntf_cnt_nx;
        ntf_byte <= ntf_sel[ntf_cnt_nx]; // [RQ4]
        ntf_last <= (ntf_cnt_nx == 2'h3);
      end
    end
  end

  // System clock domain
  logic req_q1, req_q2, req_q3, dn_q1, dn_q2, dn_q3;
  logic ctl_q1, ctl_s; // Control pin synchroniser
  logic [NP-1:0] flt_q1, flt_s; // Fault input synchronisers
  wire req_edge = req_q2 ^ req_q3;
  wire dn_edge = dn_q2 ^ dn_q3;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {req_q1, req_q2, req_q3, dn_q1, dn_q2, dn_q3} <= 6'h00;
      {ctl_q1, ctl_s} <= 2'h0;
      {flt_q1, flt_s} <= '0;
    end else begin
      {req_q1, req_q2, req_q3} <= {req_tgl, req_q1, req_q2};
      {dn_q1, dn_q2, dn_q3} <= {done_tgl, dn_q1, dn_q2};
      {ctl_q1, ctl_s} <= {ctrl_pin, ctl_q1};
      flt_q1 <= fault_in;
      flt_s <= flt_q1;
    end
  end

  // Memories: working, factory and user store per output
  logic [7:0] work [NP][NQ]; // [RQ20]
  logic [7:0] dflt [NP][NQ];
  logic [7:0] user [NP][NQ];
  logic [7:0] wp, page; // Lock byte and output selector
  cmwg_pkg::cmwg_state_t state;
  cmwg_pkg::cmwg_copy_t cop;
  logic [1:0] cidx, cend; // Copy walk
  logic cml; // Sticky failed-command flag

  // Parameter lookup: hit bit then slot
  function automatic logic [2:0] par_look(input logic [7:0] code);
    par_look = (code == cmwg_pkg::CODE_OPER) ? {1'b1, cmwg_pkg::IDX_OPER} :
               (code == cmwg_pkg::CODE_ONOFF) ? {1'b1, cmwg_pkg::IDX_ONOFF} :
               (code == cmwg_pkg::CODE_VOUT) ? {1'b1, cmwg_pkg::IDX_VOUT} :
               (code == cmwg_pkg::CODE_TRIM) ? {1'b1, cmwg_pkg::IDX_TRIM} : 3'h0;
  endfunction : par_look

  // Command decode
  wire [2:0] cmd_par = par_look(lk_code);
  wire [2:0] tgt_par = par_look(lk_data); // Code named by a one-item copy
  wire is_wp = lk_code == cmwg_pkg::CODE_WP;
  wire is_page = lk_code == cmwg_pkg::CODE_PAGE;
  wire is_all = lk_code[7:2] == cmwg_pkg::CODE_ST_DFLT_ALL[7:2];
  wire is_one = lk_code[7:2] == cmwg_pkg::CODE_ST_DFLT_ONE[7:2];
  wire [1:0] copy_op = lk_code[1:0];
  wire to_user = copy_op[1];
  // Write lock tiers
  wire tier1 = is_wp; // [RQ7]
  wire tier2 = tier1 || is_page || lk_code == cmwg_pkg::CODE_OPER; // [RQ8]
  wire tier3 = tier2 || lk_code == cmwg_pkg::CODE_ONOFF
               || lk_code == cmwg_pkg::CODE_VOUT; // [RQ9]
  wire wr_ok = wp[cmwg_pkg::WP_ALL] ? tier1 : // [RQ7]
               wp[cmwg_pkg::WP_CTRL] ? tier2 : // [RQ8]
               wp[cmwg_pkg::WP_SETPT] ? tier3 : // [RQ9]
               wp[cmwg_pkg::WP_REST] ? tier1 : 1'b1; // [RQ10]
  wire page_bad = lk_data >= 8'(NP) && lk_data != cmwg_pkg::PAGE_ALL; // [RQ21]
  wire one_bad = !tgt_par[2] || (to_user && tgt_par[1:0] == cmwg_pkg::IDX_TRIM); // [RQ18]
  wire known_wr = is_wp || is_page || cmd_par[2] || is_all || is_one;
  wire need_data = !is_all;
  wire wr_fail = !known_wr || !wr_ok || (need_data != lk_has_data)
                 || (is_page && page_bad) || (is_one && one_bad); // [RQ23]
  wire rd_fail = !(is_wp || is_page || cmd_par[2]); // [RQ6] [RQ15]
  wire ex_fail = lk_write ? wr_fail : rd_fail;
  wire ex_copy = lk_write && !wr_fail && (is_all || is_one);
  wire rd_pg = (page == cmwg_pkg::PAGE_ALL) ? 1'b0 : page[0];
  wire [7:0] rd_val = is_wp ? wp : is_page ? page : work[rd_pg][cmd_par[1:0]];
  wire [NP-1:0] pg_sel; // Outputs the selector reaches
  wire user_slot = cidx != cmwg_pkg::IDX_TRIM; // User store lacks the trim slot
  wire copy_end = cidx == cend;
  genvar g;
  for (g = 0; g < NP; g++) begin : g_sel
    assign pg_sel[g] = page == cmwg_pkg::PAGE_ALL || page == 8'(g); // [RQ22]
  end

  // Command engine and memories
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cmwg_pkg::CMWG_IDLE;
      cop <= cmwg_pkg::CMWG_ST_DFLT;
      {cidx, cend} <= 4'h0;
      wp <= cmwg_pkg::RST_WP;
      page <= cmwg_pkg::RST_PAGE; // [RQ24]
      {rsp_tgl, m_rsp_fail, cml, busy} <= 4'h0;
      m_rsp_data <= 8'h00;
      for (int p = 0; p < NP; p++) begin
        work[p] <= '{cmwg_pkg::RST_OPER, cmwg_pkg::RST_ONOFF,
                     cmwg_pkg::RST_VOUT, cmwg_pkg::RST_TRIM};
        dflt[p] <= '{cmwg_pkg::RST_OPER, cmwg_pkg::RST_ONOFF,
                     cmwg_pkg::RST_VOUT, cmwg_pkg::RST_TRIM};
        user[p] <= '{cmwg_pkg::RST_OPER, cmwg_pkg::RST_ONOFF,
                     cmwg_pkg::RST_VOUT, cmwg_pkg::RST_TRIM};
      end
    end else begin
      unique case (state)
        cmwg_pkg::CMWG_IDLE: begin
          busy <= req_edge;
          if (req_edge) state <= cmwg_pkg::CMWG_EXEC;
        end
        cmwg_pkg::CMWG_EXEC: begin
          m_rsp_fail <= ex_fail; // [RQ18] [RQ23]
          m_rsp_data <= lk_write ? 8'h00 : rd_val; // [RQ6]
          if (ex_fail) cml <= 1'b1;
          if (ex_copy) begin
            cop <= cmwg_pkg::cmwg_copy_t'(copy_op);
            cidx <= is_all ? 2'h0 : tgt_par[1:0]; // [RQ16] [RQ17]
            cend <= is_all ? 2'(NQ - 1) : tgt_par[1:0]; // [RQ15]
            state <= cmwg_pkg::CMWG_COPY;
          end else begin
            if (lk_write && !wr_fail) begin
              if (is_wp) wp <= lk_data;
              if (is_page) page <= lk_data; // [RQ21] [RQ24]
              for (int p = 0; p < NP; p++)
                if (cmd_par[2] && pg_sel[p]) work[p][cmd_par[1:0]] <= lk_data; // [RQ22]
            end
            rsp_tgl <= ~rsp_tgl;
            busy <= 1'b0;
            state <= cmwg_pkg::CMWG_IDLE;
          end
        end
        cmwg_pkg::CMWG_COPY: begin
          for (int p = 0; p < NP; p++) begin
            if (pg_sel[p]) begin
              unique case (cop)
                cmwg_pkg::CMWG_ST_DFLT: dflt[p][cidx] <= work[p][cidx]; // [RQ11] [RQ16]
                cmwg_pkg::CMWG_LD_DFLT: work[p][cidx] <= dflt[p][cidx]; // [RQ12] [RQ17]
                cmwg_pkg::CMWG_ST_USER: if (user_slot) user[p][cidx] <= work[p][cidx]; // [RQ13]
                cmwg_pkg::CMWG_LD_USER: if (user_slot) work[p][cidx] <= user[p][cidx]; // [RQ14]
              endcase
            end
          end
          cidx <= 2'(cidx + 2'h1);
          if (copy_end) begin
            rsp_tgl <= ~rsp_tgl;
            busy <= 1'b0;
            state <= cmwg_pkg::CMWG_IDLE;
          end
        end
        default: state <= cmwg_pkg::CMWG_IDLE;
      endcase
    end
  end

  // Run command per output from pin, operation byte and configuration
  logic [NP-1:0] run_on, latch, next_latch;
  for (g = 0; g < NP; g++) begin : g_run
    wire [7:0] cfg = work[g][cmwg_pkg::IDX_ONOFF];
    wire pin_on = cfg[cmwg_pkg::CFG_PIN_POL] ? ctl_s : ~ctl_s;
    wire cmd_on = work[g][cmwg_pkg::IDX_OPER][cmwg_pkg::OPER_ON];
    assign run_on[g] = !cfg[cmwg_pkg::CFG_GATED] ||
      ((!cfg[cmwg_pkg::CFG_USE_CMD] || cmd_on) && (!cfg[cmwg_pkg::CFG_USE_PIN] || pin_on));
    // Fault sets; only a commanded off clears, set wins
    assign next_latch[g] = flt_s[g] || (latch[g] && run_on[g]); // [RQ1] [RQ3]
  end

  // Fault latch and output enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= '0; // [RQ2]
      out_en <= '0;
    end else begin
      latch <= next_latch;
      out_en <= run_on & ~next_latch; // [RQ1]
    end
  end

  // Notification request on a new fault latch
  logic ntf_pend;
  wire new_fault = |(next_latch & ~latch);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {ntf_pend, ntf_tgl} <= 2'h0;
      m_ntf_word <= 16'h0000;
    end else if (new_fault && !ntf_pend) begin
      ntf_pend <= 1'b1;
      ntf_tgl <= ~ntf_tgl;
      m_ntf_word <= 16'h0000 | (16'(|next_latch) << cmwg_pkg::ST_FAULT)
                  | (16'(~&(run_on & ~next_latch)) << cmwg_pkg::ST_OFF)
                  | (16'(cml) << cmwg_pkg::ST_CML); // [RQ4]
    end else if (dn_edge) begin
      ntf_pend <= 1'b0;
    end
  end

  // Checks on the mclk side, except the notify byte check on link_clk
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_copy_all;
    state == cmwg_pkg::CMWG_EXEC && ex_copy && is_all;
  endsequence
  a_fault_holds_off: assert property (latch[0] && run_on[0] |=> !out_en[0]) // [RQ1]
    else $error("output enabled while fault latched");
  a_off_clears_latch: assert property (!run_on[0] && !flt_s[0] |=> !latch[0]) // [RQ3]
    else $error("commanded off did not clear fault");
  a_lock_all_refuses: assert property (state == cmwg_pkg::CMWG_EXEC && lk_write
    && wp[7] && !is_wp |=> m_rsp_fail && $stable(page)) // [RQ7]
    else $error("write passed full lock");
  a_read_always_ok: assert property (state == cmwg_pkg::CMWG_EXEC && !lk_write
    && cmd_par[2] |=> !m_rsp_fail) // [RQ6]
    else $error("read of parameter refused");
  a_bad_code_fails: assert property (state == cmwg_pkg::CMWG_EXEC && lk_write
    && is_one && !tgt_par[2] |=> m_rsp_fail) // [RQ18]
    else $error("unknown code copy not failed");
  a_copy_all_walk: assert property (s_copy_all |=> busy [*4] ##1 !busy) // [RQ11]
    else $error("whole copy length wrong");
  a_select_holds: assert property (state != cmwg_pkg::CMWG_EXEC |=> $stable(page)) // [RQ24]
    else $error("selector changed without write");
  a_all_pages_write: assert property (state == cmwg_pkg::CMWG_EXEC && lk_write
    && !wr_fail && cmd_par[2] && page == cmwg_pkg::PAGE_ALL
    |=> work[1][$past(cmd_par[1:0])] == $past(lk_data)) // [RQ22]
    else $error("all-output write missed an output");
  a_notify_low_first: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ntf_valid && ntf_cnt == 2'h2 |-> ntf_byte == m_ntf_word[7:0]) // [RQ4]
    else $error("low status byte not third");
endmodule : cmwg_top

// >>> test/cmwg_host_model.sv
// Host-side model that acknowledges fault notification bytes.
// Assumes the link_clk domain and the bench's active-low reset.
`timescale 1ns/100ps
module cmwg_host_model (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic ntf_valid,
  output logic ntf_ack
);
  logic [1:0] wait_cnt; // Cycles left before the next ack
  logic [1:0] pace; // Rotates prompt and slow answers
  // Acknowledge each offered byte, at once or a few cycles late
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      ntf_ack <= 1'b0;
      wait_cnt <= 2'h0;
      pace <= 2'h0;
    end else if (ntf_ack) begin
      // One ack per byte, then withdraw it
      ntf_ack <= 1'b0;
      wait_cnt <= pace;
      pace <= pace + 2'h1;
    end else if (ntf_valid) begin
      if (wait_cnt == 2'h0) begin
        ntf_ack <= 1'b1; // Host acknowledges the byte
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : cmwg_host_model

// >>> test/test_cmwg_top.sv
// Self-checking bench: commands, write lock, copies, selector, faults.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/100ps
module test_cmwg_top;
  logic mclk = 1'b0; // System clock, 50 ns
  logic link_clk = 1'b0; // Link clock, 15 ns
  logic nrst = 1'b0; // Reset, low active
  logic ctrl_pin = 1'b1; // Pin held in the run state
  logic [1:0] fault_in = 2'h0; // Fault conditions per output
  logic link_req = 1'b0, link_write = 1'b0, link_has_data = 1'b0; // Strobe and kind
  logic [7:0] link_code = 8'h00, link_data = 8'h00; // Command fields
  logic ntf_ack, busy, link_busy, link_rsp, link_rsp_fail, ntf_valid, ntf_last;
  logic [1:0] out_en; // Output enables
  logic [7:0] link_rsp_data, ntf_byte; // Answer and notify bytes
  logic [9:0] rsp_q[$]; // Noted answers: check data, fail, data
  logic [8:0] ntf_q[$]; // Noted notify bytes: last, byte
  logic [9:0] e; // Oldest answer note
  logic [8:0] f; // Oldest notify note
  logic [7:0] wm[4]; // Expected working values of output 0
  logic [7:0] lks[6] = '{8'h80, 8'h40, 8'h20, 8'h1E, 8'h01, 8'h00}; // Lock values
  logic [7:0] code, v, r1, r3; // Scratch values
  logic ok; // Write expected to pass
  int fails = 0, tests_run = 0, seed = 28637;

  // System clock
  always #25 mclk = ~mclk;
  // Link clock, offset so its edges drift against mclk
  initial begin
    #4.1;
    forever #7.5 link_clk = ~link_clk;
  end

  cmwg_top u_dut (.mclk(mclk), .nrst(nrst), .ctrl_pin(ctrl_pin), .fault_in(fault_in),
    .link_clk(link_clk), .link_req(link_req), .link_write(link_write),
    .link_has_data(link_has_data), .link_code(link_code), .link_data(link_data),
    .ntf_ack(ntf_ack), .out_en(out_en), .busy(busy), .link_busy(link_busy),
    .link_rsp(link_rsp), .link_rsp_fail(link_rsp_fail), .link_rsp_data(link_rsp_data),
    .ntf_valid(ntf_valid), .ntf_last(ntf_last), .ntf_byte(ntf_byte));
  cmwg_host_model u_host (.link_clk(link_clk), .nrst(nrst), .ntf_valid(ntf_valid),
    .ntf_ack(ntf_ack));

  // Compare one result, count it, report a mismatch
  task automatic compare(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  // Summary and verdict, then stop
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // One command; the answer is noted before the request goes out
  task automatic cmd(input logic wr, hd, input logic [7:0] c, d, input logic fl,
                     input logic [7:0] rd);
    int n;
    logic hb;
    rsp_q.push_back({~wr & ~fl, fl, rd});
    @(posedge link_clk);
    link_req <= 1'b1;
    link_write <= wr;
    link_has_data <= hd;
    link_code <= c;
    link_data <= hd ? d : 8'($random(seed));
    @(posedge link_clk);
    link_req <= 1'b0;
    link_code <= 8'($random(seed));
    n = 0;
    hb = 1'b0;
    do begin
      @(negedge link_clk);
      n++;
      if (n == 1) compare("link busy held", 9'h001, {8'h00, link_busy});
      if (busy === 1'b1) hb = 1'b1;
    end while (link_rsp !== 1'b1 && n < 80);
    if (n >= 80) compare("answer pulse", 9'h001, 9'h000);
    compare("engine busy seen", 9'h001, {8'h00, hb});
  endtask : cmd

  // Short forms: write, read, copy
  task automatic wr(input logic [7:0] c, d, input logic fl);
    cmd(1'b1, 1'b1, c, d, fl, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] c, x);
    cmd(1'b0, 1'b0, c, 8'h00, 1'b0, x);
  endtask : rd
  task automatic cp(input logic [7:0] c, input logic h, input logic [7:0] d, input logic fl);
    cmd(1'b1, h, c, d, fl, 8'h00);
  endtask : cp

  // Whether a write of code c passes lock value k
  function automatic logic allow(input logic [7:0] k, c);
    if (c == 8'h50) return 1'b1;
    if (k[7]) return 1'b0;
    if (k[6]) return c == 8'h41 || c == 8'h51;
    if (k[5]) return c inside {8'h41, 8'h42, 8'h43, 8'h51};
    return !k[0];
  endfunction : allow

  // Bounded wait for the enables, then compare
  task automatic wait_out(input logic [1:0] x);
    int n;
    n = 0;
    while (out_en !== x && n < 200) begin
      @(negedge mclk);
      n++;
    end
    compare("output enable", {7'h00, x}, {7'h00, out_en});
  endtask : wait_out

  // Note the four notify bytes, then raise a fault
  task automatic fault(input int o, input logic [7:0] lo);
    ntf_q.push_back(9'h010);
    ntf_q.push_back(9'h054);
    ntf_q.push_back({1'b0, lo});
    ntf_q.push_back(9'h108);
    @(posedge mclk);
    fault_in[o] <= 1'b1;
  endtask : fault

  // Bounded wait until every noted notify byte was seen
  task automatic wait_ntf;
    int n;
    n = 0;
    while (ntf_q.size() > 0 && n < 500) begin
      @(negedge link_clk);
      n++;
    end
    compare("notify bytes left", 9'h000, 9'(ntf_q.size()));
    @(posedge mclk);
    fault_in <= 2'h0;
  endtask : wait_ntf

  // Reset held for 20 cycles
  task automatic do_reset;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : do_reset

  // Answer watcher
  always @(negedge link_clk) begin
    if (link_rsp === 1'b1) begin
      compare("link busy at answer", 9'h000, {8'h00, link_busy});
      if (rsp_q.size() == 0) compare("unexpected answer", 9'h000, 9'h001);
      else begin
        e = rsp_q.pop_front();
        compare("answer fail flag", {8'h00, e[8]}, {8'h00, link_rsp_fail});
        if (e[9]) compare("read data", {1'b0, e[7:0]}, {1'b0, link_rsp_data});
      end
    end
  end

  // Notify watcher: each acked byte
  always @(negedge link_clk) begin
    if (ntf_valid === 1'b1 && ntf_ack === 1'b1) begin
      if (ntf_q.size() == 0) compare("unexpected notify byte", 9'h000, 9'h001);
      else begin
        f = ntf_q.pop_front();
        compare("notify byte", f, {ntf_last, ntf_byte});
      end
    end
  end

  // Watchdog
  initial begin
    #2_000_000;
    compare("run finished", 9'h001, 9'h000);
    print_verdict();
  end

  // Main sequence
  initial begin
    do_reset();
    rd(8'h50, 8'h00);
    rd(8'h51, 8'h00);
    wait_out(2'h3);
    // Fault latch and notification
    fault(0, 8'h40);
    wait_out(2'h2);
    wait_ntf();
    repeat (40) @(posedge mclk);
    compare("output enable", 9'h002, {7'h00, out_en});
    wr(8'h41, 8'h00, 1'b0);
    wr(8'h41, 8'h80, 1'b0);
    wait_out(2'h3);
    // Write lock table over six lock settings
    wm = '{8'h80, 8'h1E, 8'h00, 8'h00};
    foreach (lks[i]) begin
      wr(8'h50, lks[i], 1'b0);
      for (int c = 0; c < 5; c++) begin
        code = (c == 4) ? 8'h51 : 8'h41 + 8'(c);
        v = (c == 1) ? 8'h1E : (c == 4) ? 8'h00 : 8'($random(seed));
        if (c == 0) v = v | 8'h80;
        ok = allow(lks[i], code);
        wr(code, v, ~ok);
        if (ok && c < 4) wm[c] = v;
        rd(code, (c == 4) ? 8'h00 : wm[c]);
      end
      rd(8'h50, lks[i]);
    end
    // Whole and one-item copies
    r1 = 8'($random(seed));
    r3 = r1 + 8'h11;
    wr(8'h43, r1, 1'b0);
    cp(8'h62, 1'b0, 8'h00, 1'b0);
    wr(8'h43, ~r1, 1'b0);
    wr(8'h44, 8'h5A, 1'b0);
    cp(8'h63, 1'b0, 8'h00, 1'b0);
    rd(8'h43, r1);
    rd(8'h44, 8'h5A);
    cp(8'h60, 1'b0, 8'h00, 1'b0);
    wr(8'h44, 8'hA5, 1'b0);
    wr(8'h43, ~r1, 1'b0);
    cp(8'h61, 1'b0, 8'h00, 1'b0);
    rd(8'h44, 8'h5A);
    rd(8'h43, r1);
    wr(8'h43, r3, 1'b0);
    cp(8'h66, 1'b1, 8'h43, 1'b0);
    wr(8'h43, r1, 1'b0);
    wr(8'h44, 8'hC3, 1'b0);
    cp(8'h67, 1'b1, 8'h43, 1'b0);
    rd(8'h43, r3);
    rd(8'h44, 8'hC3);
    cp(8'h64, 1'b1, 8'h44, 1'b0);
    wr(8'h44, 8'h3C, 1'b0);
    cp(8'h65, 1'b1, 8'h44, 1'b0);
    rd(8'h44, 8'hC3);
    cp(8'h66, 1'b1, 8'h44, 1'b1);
    cp(8'h64, 1'b1, 8'h99, 1'b1);
    cp(8'h65, 1'b1, 8'h99, 1'b1);
    cp(8'h60, 1'b1, 8'h00, 1'b1);
    cp(8'h64, 1'b0, 8'h00, 1'b1);
    cmd(1'b0, 1'b0, 8'h61, 8'h00, 1'b1, 8'h00);
    // Selector steering
    wr(8'h51, 8'h01, 1'b0);
    wr(8'h43, 8'hA1, 1'b0);
    wr(8'h51, 8'h00, 1'b0);
    wr(8'h43, 8'hB2, 1'b0);
    wr(8'h51, 8'h01, 1'b0);
    rd(8'h43, 8'hA1);
    wr(8'h51, 8'hFF, 1'b0);
    wr(8'h43, 8'hC7, 1'b0);
    wr(8'h51, 8'h00, 1'b0);
    rd(8'h43, 8'hC7);
    wr(8'h51, 8'h01, 1'b0);
    rd(8'h43, 8'hC7);
    wr(8'h51, 8'h02, 1'b1);
    wr(8'h51, 8'h1F, 1'b1);
    rd(8'h51, 8'h01);
    // Fault on output 1, cleared by the pin, then again and cleared by reset
    fault(1, 8'h42);
    wait_out(2'h1);
    wait_ntf();
    @(posedge mclk);
    ctrl_pin <= 1'b0;
    wait_out(2'h0);
    @(posedge mclk);
    ctrl_pin <= 1'b1;
    wait_out(2'h3);
    fault(1, 8'h42);
    wait_out(2'h1);
    wait_ntf();
    do_reset();
    wait_out(2'h3);
    rd(8'h51, 8'h00);
    print_verdict();
  end
endmodule : test_cmwg_top
